// file: src/pec_pkg.sv
package pec_pkg;

	// Instruction encoding
	localparam logic [7:0] PEC_OPC_B0 = 8'h0F;
	localparam logic [7:0] PEC_OPC_B1 = 8'h01;
	localparam logic [7:0] PEC_OPC_B2 = 8'hCF;

	// Exit bitmap layout
	localparam int PEC_BITMAP_W = 64;
	localparam logic [31:0] PEC_BITMAP_LAST = 32'h0000003F;
	localparam logic [31:0] PEC_LEAF_MAX_LOW = 32'h0000003E;

	// Default number of defined leaves
	localparam logic [31:0] PEC_NUM_LEAVES_DEF = 32'h00000013;
	// Epoch-tracking leaf indices, plain defaults
	localparam logic [31:0] PEC_LEAF_TRACK_DEF = 32'h0000000C;
	localparam logic [31:0] PEC_LEAF_TRACKC_DEF = 32'h00000011;

	localparam logic [15:0] PEC_GP_ERRCODE = 16'h0000;

	// Status / mask bit positions
	localparam int PEC_EV_UD = 0;
	localparam int PEC_EV_GP = 1;
	localparam int PEC_EV_EXIT = 2;
	localparam int PEC_EV_ABORT = 3;
	localparam int PEC_EV_CONFLICT = 4;
	localparam int PEC_EV_W = 5;

	// Register offsets
	localparam logic [3:0] PEC_OFF_STATUS = 4'h0;
	localparam logic [3:0] PEC_OFF_MASK = 4'h1;
	localparam logic [3:0] PEC_OFF_LAST = 4'h2;
	localparam logic [PEC_EV_W-1:0] PEC_MASK_RST = 5'h00;

	typedef enum {
		PEC_RES_NONE,
		PEC_RES_ABORT,
		PEC_RES_UD,
		PEC_RES_EXIT,
		PEC_RES_GP,
		PEC_RES_CONFLICT,
		PEC_RES_DISPATCH
	} pec_result_t;

	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic pfx_lock;
		logic pfx_opsize;
		logic pfx_rep;
		logic pfx_vex;
		logic pfx_segovr;
		logic pfx_addrsize;
		logic pfx_rex;
	} pec_insn_t;

	typedef struct packed {
		logic protection_enable_bit;
		logic paging_enable_bit;
		logic virtual_8086_flag;
		logic system_management_mode;
		logic [1:0] current_privilege_level;
		logic long_mode_active_bit;
		logic cs_long;
		logic ds_expand_down;
		logic transactional_execution;
		logic guest_mode;
		logic call_exiting_enable;
		logic feature_control_lock_bit;
		logic enclave_feature_enable_bit;
		logic enclave_base_capability_bit;
	} pec_state_t;

	typedef struct packed {
		logic [31:0] leaf;
		logic [63:0] op_b;
		logic [63:0] op_c;
		logic [63:0] op_d;
		logic addr64;
	} pec_dispatch_t;

endpackage : pec_pkg

// file: src/pec_checker.sv
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Opcode 0F 01 CF with no mandatory prefix is the call, both modes.
// - Leaf comes from the low 32 accumulator bits; upper half ignored.
// - Invalid-opcode when protection off, virtual-8086 set, or system management mode.
// - Invalid-opcode when privilege level above zero.
// - General-protection zero when paging off or leaf undefined.
// - Guest with exiting on: exit on bitmap bit of leaf, bit 63 above 62.
// - After exit check, general-protection zero if lock or enable bit clear.
// - General-protection zero outside 64-bit mode with expand-down data segment.
// - 32-bit addressing outside 64-bit mode, 64-bit inside; data segment used.
// - Segment, address-size and REX prefixes are ignored.
// - Invalid-opcode on lock, 66H, rep or vex prefix.
// - Invalid-opcode when base enclave capability bit 0 is clear.
// - Active transactional region aborts before every other check.
// - Compatibility mode checks as protected; real and virtual-8086 give invalid-opcode.
// - Tracking leaves exclusive on control structure; conflict in guest mode flagged with tracker qualifier.
// - Exit bitmap bit index equals the leaf index for leaves up to 62.
module pec_checker import pec_pkg::*; #(
	parameter logic [31:0] NUM_LEAVES = PEC_NUM_LEAVES_DEF,
	parameter logic [31:0] LEAF_TRACK = PEC_LEAF_TRACK_DEF,
	parameter logic [31:0] LEAF_TRACKC = PEC_LEAF_TRACKC_DEF
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic insn_valid,
	input wire pec_insn_t insn,
	input wire pec_state_t cpu,
	input wire logic [63:0] wide_accumulator,
	input wire logic [63:0] reg_b,
	input wire logic [63:0] reg_c,
	input wire logic [63:0] reg_d,
	input wire logic [PEC_BITMAP_W-1:0] exit_bitmap,
	input wire logic tracker_busy,
	input wire logic track_done,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic is_call,
	output logic invalid_opcode_fault,
	output logic general_protection_fault,
	output logic [15:0] gp_error_code,
	output logic hypervisor_exit,
	output logic transaction_abort,
	output logic enclave_page_conflict_code,
	output logic tracker_contention_qualifier,
	output logic dispatch_valid,
	output pec_dispatch_t dispatch,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// Decode and checks

	function automatic logic is_tracking(input logic [31:0] leaf);
		is_tracking = (leaf == LEAF_TRACK) || (leaf == LEAF_TRACKC);
	endfunction : is_tracking

	logic opc_match;
	logic [31:0] leaf_index_register;
	logic in64;
	logic chk_ud;
	logic chk_exit;
	logic chk_gp;
	logic chk_conflict;
	logic [5:0] bm_idx;
	pec_result_t result;
	logic tracker_held_reg;
	logic [PEC_EV_W-1:0] status_reg;
	logic [PEC_EV_W-1:0] mask_reg;
	logic [PEC_EV_W-1:0] events;
	logic [2:0] last_reg;

	// Segment-override, address-size and REX prefixes are not examined
	assign opc_match = insn_valid && insn.b0 == PEC_OPC_B0 && insn.b1 == PEC_OPC_B1
		&& insn.b2 == PEC_OPC_B2;
	assign leaf_index_register = wide_accumulator[31:0];
	assign in64 = cpu.long_mode_active_bit && cpu.cs_long;

	// Real and virtual-8086 modes fall under the protection and VM tests
	assign chk_ud = !cpu.protection_enable_bit || cpu.virtual_8086_flag
		|| cpu.system_management_mode || !cpu.enclave_base_capability_bit
		|| insn.pfx_lock || insn.pfx_opsize || insn.pfx_rep || insn.pfx_vex
		|| (cpu.current_privilege_level != 2'h0);

	assign bm_idx = (leaf_index_register > PEC_LEAF_MAX_LOW) ? PEC_BITMAP_LAST[5:0]
		: leaf_index_register[5:0];
	assign chk_exit = cpu.guest_mode && cpu.call_exiting_enable && exit_bitmap[bm_idx];

	assign chk_gp = !cpu.feature_control_lock_bit || !cpu.enclave_feature_enable_bit
		|| (leaf_index_register >= NUM_LEAVES) || !cpu.paging_enable_bit
		|| (!in64 && cpu.ds_expand_down);

	assign chk_conflict = is_tracking(leaf_index_register) && (tracker_busy || tracker_held_reg);

	always_comb begin
		result = PEC_RES_NONE;
		if (opc_match) begin
			if (cpu.transactional_execution) begin
				result = PEC_RES_ABORT;
			end else if (chk_ud) begin
				result = PEC_RES_UD;
			end else if (chk_exit) begin
				result = PEC_RES_EXIT;
			end else if (chk_gp) begin
				result = PEC_RES_GP;
			end else if (chk_conflict) begin
				result = PEC_RES_CONFLICT;
			end else begin
				result = PEC_RES_DISPATCH;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result outputs

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			is_call <= 1'b0;
			invalid_opcode_fault <= 1'b0;
			general_protection_fault <= 1'b0;
			gp_error_code <= PEC_GP_ERRCODE;
			hypervisor_exit <= 1'b0;
			transaction_abort <= 1'b0;
			enclave_page_conflict_code <= 1'b0;
			tracker_contention_qualifier <= 1'b0;
			dispatch_valid <= 1'b0;
		end else begin
			is_call <= opc_match;
			invalid_opcode_fault <= (result == PEC_RES_UD);
			general_protection_fault <= (result == PEC_RES_GP);
			gp_error_code <= PEC_GP_ERRCODE;
			transaction_abort <= (result == PEC_RES_ABORT);
			enclave_page_conflict_code <= (result == PEC_RES_CONFLICT);
			// Conflict qualifier applies when the conflict lands in guest mode
			hypervisor_exit <= (result == PEC_RES_EXIT) || (result == PEC_RES_CONFLICT && cpu.guest_mode);
			tracker_contention_qualifier <= (result == PEC_RES_CONFLICT) && cpu.guest_mode;
			dispatch_valid <= (result == PEC_RES_DISPATCH);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dispatch <= '0;
		end else if (result == PEC_RES_DISPATCH) begin
			dispatch.leaf <= leaf_index_register;
			dispatch.op_b <= in64 ? reg_b : {32'h00000000, reg_b[31:0]};
			dispatch.op_c <= in64 ? reg_c : {32'h00000000, reg_c[31:0]};
			dispatch.op_d <= in64 ? reg_d : {32'h00000000, reg_d[31:0]};
			dispatch.addr64 <= in64;
		end
	end

	// A dispatched tracking leaf owns the control structure until done
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tracker_held_reg <= 1'b0;
		end else if (result == PEC_RES_DISPATCH && is_tracking(leaf_index_register)) begin
			tracker_held_reg <= 1'b1;
		end else if (track_done) begin
			tracker_held_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status, mask, interrupt and register port

	assign events = {result == PEC_RES_CONFLICT, result == PEC_RES_ABORT, result == PEC_RES_EXIT,
		result == PEC_RES_GP, result == PEC_RES_UD};

	// Set wins over write-one-to-clear
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			status_reg <= '0;
		end else if (reg_wr && reg_addr == PEC_OFF_STATUS) begin
			status_reg <= (status_reg & ~reg_wdata[PEC_EV_W-1:0]) | events;
		end else begin
			status_reg <= status_reg | events;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mask_reg <= PEC_MASK_RST;
		end else if (reg_wr && reg_addr == PEC_OFF_MASK) begin
			mask_reg <= reg_wdata[PEC_EV_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			last_reg <= 3'h0;
		end else if (opc_match) begin
			last_reg <= 3'(result);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				PEC_OFF_STATUS: reg_rdata <= {27'h0000000, status_reg};
				PEC_OFF_MASK: reg_rdata <= {27'h0000000, mask_reg};
				PEC_OFF_LAST: reg_rdata <= {28'h0000000, tracker_held_reg, last_reg};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	assign irq = |(status_reg & mask_reg);

endmodule : pec_checker

`default_nettype wire

// file: testbench/pec_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pec_checker_asserts import pec_pkg::*; (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic insn_valid,
	input wire pec_insn_t insn,
	input wire pec_state_t cpu,
	input wire logic [63:0] wide_accumulator,
	input wire logic [15:0] gp_error_code,
	input wire logic is_call,
	input wire logic invalid_opcode_fault,
	input wire logic general_protection_fault,
	input wire logic hypervisor_exit,
	input wire logic transaction_abort,
	input wire logic dispatch_valid,
	input wire pec_dispatch_t dispatch,
	input wire logic irq
);
	logic opc;
	logic ok;
	assign opc = insn_valid && insn.b0 == PEC_OPC_B0 && insn.b1 == PEC_OPC_B1 && insn.b2 == PEC_OPC_B2;
	assign ok = opc && !cpu.transactional_execution;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////
	a_abort_first: assert property (opc && cpu.transactional_execution
		|=> transaction_abort && !invalid_opcode_fault) else $error("abort not first");
	a_ud_mode: assert property (ok && (!cpu.protection_enable_bit || cpu.virtual_8086_flag
		|| cpu.system_management_mode) |=> invalid_opcode_fault) else $error("mode fault missing");
	a_ud_level: assert property (ok && cpu.current_privilege_level != 2'h0
		|=> invalid_opcode_fault) else $error("level fault missing");
	a_ud_prefix: assert property (ok && (insn.pfx_lock || insn.pfx_opsize || insn.pfx_rep || insn.pfx_vex)
		|=> invalid_opcode_fault) else $error("prefix fault missing");
	a_ud_capab: assert property (ok && !cpu.enclave_base_capability_bit
		|=> invalid_opcode_fault) else $error("capability fault missing");
	a_gp_zero: assert property (general_protection_fault |-> gp_error_code == PEC_GP_ERRCODE)
		else $error("error code not zero");
	a_leaf_low: assert property (dispatch_valid
		|-> dispatch.leaf == $past(wide_accumulator[31:0])) else $error("leaf mismatch");
	a_addr_size: assert property (dispatch_valid
		|-> dispatch.addr64 == $past(cpu.long_mode_active_bit && cpu.cs_long)) else $error("size mismatch");
	a_one_result: assert property ($onehot0({invalid_opcode_fault, general_protection_fault,
		transaction_abort, dispatch_valid})) else $error("several results");
	a_not_call: assert property (insn_valid && !opc
		|=> !is_call && !dispatch_valid && !invalid_opcode_fault) else $error("wrong opcode taken");
	cover property (dispatch_valid);
	cover property (hypervisor_exit);
	cover property (irq);
endmodule : pec_checker_asserts
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import pec_pkg::*;;
	localparam pec_state_t G = 15'h6187;
	localparam pec_insn_t I = {PEC_OPC_B0, PEC_OPC_B1, PEC_OPC_B2, 7'h00};
	localparam logic [5:0] ABT = 6'h20, UD = 6'h10, EX = 6'h08, GP = 6'h04, CF = 6'h02, DS = 6'h01;
	logic sys_clk = 1'b0, srst = 1'b1, insn_valid = 1'b0, tracker_busy = 1'b0, track_done = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	pec_insn_t insn = '0;
	pec_state_t cpu = '0;
	logic [63:0] wide_accumulator = '0, reg_b = '0, reg_c = '0, reg_d = '0, exit_bitmap = '0;
	logic [3:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata;
	logic is_call, invalid_opcode_fault, general_protection_fault, hypervisor_exit, transaction_abort;
	logic enclave_page_conflict_code, tracker_contention_qualifier, dispatch_valid, irq;
	logic [15:0] gp_error_code;
	pec_dispatch_t dispatch;
	int mismatches = 0, check_count = 0;
	pec_checker u_dut (.sys_clk, .srst, .insn_valid, .insn, .cpu, .wide_accumulator, .reg_b, .reg_c, .reg_d,
		.exit_bitmap, .tracker_busy, .track_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .is_call,
		.invalid_opcode_fault, .general_protection_fault, .gp_error_code, .hypervisor_exit, .transaction_abort,
		.enclave_page_conflict_code, .tracker_contention_qualifier, .dispatch_valid, .dispatch, .irq);
	always #2.5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic go(input pec_state_t s, input pec_insn_t i, input logic [63:0] a, input logic [5:0] e);
		@(posedge sys_clk);
		insn_valid <= 1'b1;
		cpu <= s;
		insn <= i;
		wide_accumulator <= a;
		@(posedge sys_clk);
		insn_valid <= 1'b0;
		#1 chk({transaction_abort, invalid_opcode_fault, hypervisor_exit, general_protection_fault,
			enclave_page_conflict_code, dispatch_valid}, e);
	endtask : go
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	task automatic results;
		$display("mismatches=%0d checks=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////
	initial begin
		pec_state_t s;
		pec_insn_t i;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		exit_bitmap <= 64'h8000_0000_0000_0020;
		reg_b <= 64'hF123_4567_89AB_CDEF;
		rd(PEC_OFF_MASK, 32'h0);
		go(G, I, 64'hFFFF_FFFF_0000_0003, DS);
		chk(is_call, 1'b1);
		chk(dispatch.leaf, 32'h3);
		chk(dispatch.op_b, 64'hF123_4567_89AB_CDEF);
		chk(dispatch.addr64, 1'b1);
		s = G; s.transactional_execution = 1'b1; s.current_privilege_level = 2'h3;
		go(s, I, 64'h0, ABT);
		s = G; s.protection_enable_bit = 1'b0; go(s, I, 64'h0, UD);
		s = G; s.virtual_8086_flag = 1'b1; go(s, I, 64'h0, UD);
		s = G; s.system_management_mode = 1'b1; go(s, I, 64'h0, UD);
		s = G; s.current_privilege_level = 2'h1; go(s, I, 64'h0, UD);
		s = G; s.enclave_base_capability_bit = 1'b0; go(s, I, 64'h0, UD);
		for (int k = 0; k < 7; k++) begin
			i = I; i[k] = 1'b1; go(G, i, 64'h0, k > 2 ? UD : DS);
		end
		s = G; s.guest_mode = 1'b1; s.call_exiting_enable = 1'b1;
		go(s, I, 64'h5, EX);
		go(s, I, 64'h6, DS);
		go(s, I, 64'h50, EX);
		go(s, I, 64'h3E, GP);
		s.feature_control_lock_bit = 1'b0; go(s, I, 64'h5, EX);
		go(s, I, 64'h6, GP);
		s = G; s.enclave_feature_enable_bit = 1'b0; go(s, I, 64'h0, GP);
		s = G; s.paging_enable_bit = 1'b0; go(s, I, 64'h0, GP);
		go(G, I, 64'h13, GP);
		chk(gp_error_code, 16'h0000);
		go(G, I, 64'h12, DS);
		s = G; s.cs_long = 1'b0; s.ds_expand_down = 1'b1; go(s, I, 64'h0, GP);
		s.cs_long = 1'b1; go(s, I, 64'h0, DS);
		s.cs_long = 1'b0; s.ds_expand_down = 1'b0; go(s, I, 64'h1, DS);
		chk(dispatch.op_b, 64'h89AB_CDEF);
		chk(dispatch.addr64, 1'b0);
		i = I; i.b2 = 8'hD7; go(G, i, 64'h0, 6'h00);
		chk(is_call, 1'b0);
		@(posedge sys_clk) tracker_busy <= 1'b1;
		go(G, I, 64'hC, CF);
		@(posedge sys_clk) tracker_busy <= 1'b0;
		go(G, I, 64'h11, DS);
		rd(PEC_OFF_LAST, 32'hE);
		go(G, I, 64'hC, CF);
		@(posedge sys_clk) track_done <= 1'b1;
		@(posedge sys_clk) track_done <= 1'b0;
		go(G, I, 64'hC, DS);
		s = G; s.guest_mode = 1'b1; s.call_exiting_enable = 1'b1;
		go(s, I, 64'h11, EX | CF);
		chk(tracker_contention_qualifier, 1'b1);
		wr(PEC_OFF_STATUS, 32'h1F);
		s = G; s.protection_enable_bit = 1'b0; go(s, I, 64'h0, UD);
		rd(PEC_OFF_STATUS, 32'h1);
		chk(irq, 1'b0);
		wr(PEC_OFF_MASK, 32'h1);
		chk(irq, 1'b1);
		wr(PEC_OFF_STATUS, 32'h1);
		chk(irq, 1'b0);
		rd(4'hF, 32'h0);
		results;
	end
endmodule : tb
bind pec_checker pec_checker_asserts u_chk (.sys_clk, .srst, .insn_valid, .insn, .cpu, .wide_accumulator,
	.gp_error_code, .is_call, .invalid_opcode_fault, .general_protection_fault, .hypervisor_exit,
	.transaction_abort, .dispatch_valid, .dispatch, .irq);
`default_nettype wire
